// *** core/rpd_reset_ctrl.sv ***
/*
 * Reset distribution and internal-PHY power-down control.
 * Assumes hw_reset_n_pin arrives asynchronously from a board pin with
 * an external or pad pull-up; all other inputs are on clock.
 */
// Notes on behaviour
// - PHY powered down, management kept alive, while general power-down bit set.
// - Clearing the power-down bit powers the PHY up and resets it.
// - Energy-detect enable powers PHY down except squelch and detector.
// - In energy-detect mode without line energy PHY stays down, silent.
// - Line energy powers PHY up, keeps its state, sets energy flag.
// - Energy flag raises host interrupt when its enable is set.
// - First one or two waking packets may be lost.
// - Hardware pin resets everything, reloads MAC address, latches straps.
// - Soft reset hits bus, MAC layer and MAC, reloads MAC address.
// - After PHY reset, transmit is held until link status is up.
// - EEPROM probed after full or soft reset; busy flag shown meanwhile.
// - Ready rises about 22 ms after pin release, at once after soft reset ends; host times out 100 ms.
// - Ready reads zero while pin low and until hardware reset done.
// - Pin may float high; unused pin needs host soft reset.
// - Wake write sets ready within 2 ms.
// - Soft reset bit starts reset and self-clears about 2 us later.
// - PHY reset bit resets PHY only, self-clears after about 100 us.
// - PHY basic-control reset bit resets PHY only, self-clears when done.
// - Any wake-register write while sleeping returns to normal.
`timescale 1ns/10ps
`include "rpd_defs.svh"

module rpd_reset_ctrl (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Board pin and straps
   input wire logic hw_reset_n_pin,
   input wire logic [3:0] config_straps,
   // Host control writes (one-cycle pulses)
   input wire logic soft_reset_wr,
   input wire logic phy_reset_wr,
   input wire logic phy_bcr_reset_wr,
   input wire logic wake_test_wr,
   input wire logic sleep_enter,
   // PHY control levels
   input wire logic phy_pdown_ctl,
   input wire logic phy_edpd_ctl,
   input wire logic energy_irq_en,
   input wire logic energy_irq_clr,
   // PHY line and link state
   input wire logic line_energy_present,
   input wire logic phy_link_up,
   // Transmit request from the MAC
   input wire logic tx_data_pending,
   // Register read-back
   output logic ready_flag,
   output logic soft_reset_bit,
   output logic phy_reset_bit,
   output logic phy_bcr_reset_bit,
   output logic eeprom_busy,
   output logic energy_irq_flag,
   output logic host_irq,
   output logic [3:0] strap_latched,
   // Reset outputs, active low; EEPROM reload pulse, active high
   output logic pll_rst_n,
   output logic host_bus_interface_rst_n,
   output logic not_cleared_by_soft_reset_rst_n,
   output logic mac_interface_layer_rst_n,
   output logic mac_rst_n,
   output logic phy_rst_n,
   output logic eeprom_reload,
   // PHY power and transmit gating
   output logic phy_power_on,
   output logic phy_mgmt_on,
   output logic phy_squelch_on,
   output logic phy_tx_enable,
   output logic tx_allow
);

   //--------------------------------------------------------------
   // Pin synchroniser
   //--------------------------------------------------------------
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic pin_prev_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg <= hw_reset_n_pin;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   wire hw_active = ~pin_sync_reg;
   // Release edge of the synchronised pin starts the post-reset sequence
   wire hw_release = pin_sync_reg & ~pin_prev_reg;

   //--------------------------------------------------------------
   // Soft reset and PHY-only reset timers
   //--------------------------------------------------------------
   logic soft_busy;
   logic phy_rst_busy;
   logic phy_auto_busy;
   logic probe_busy;
   logic ready_busy;
   logic ready_done;
   logic wake_done;
   logic bcr_done;

   // Soft reset is ignored while the pin holds the device in reset
   wire soft_start = soft_reset_wr & ~hw_active;
   wire phy_start = phy_reset_wr & ~hw_active;

   rpd_timer #(.LOAD(24'(`RPD_SOFT_CYC))) u_soft (
      .clock(clock),
      .rst_b(rst_b),
      .start(soft_start),
      .busy(soft_busy),
      .done()
   );

   rpd_timer #(.LOAD(24'(`RPD_PHYRST_CYC))) u_phyrst (
      .clock(clock),
      .rst_b(rst_b),
      .start(phy_start),
      .busy(phy_rst_busy),
      .done()
   );

   //--------------------------------------------------------------
   // PHY power state
   //--------------------------------------------------------------
   rpd_pkg::rpd_phy_state_t phy_state_reg;
   rpd_pkg::rpd_phy_state_t phy_state_next;
   logic energy_prev_reg;
   logic energy_flag_reg;
   logic bcr_busy_reg;

   wire energy_rise = line_energy_present & ~energy_prev_reg;

   always_comb begin
      phy_state_next = phy_state_reg;
      case (phy_state_reg)
         rpd_pkg::RPD_PHY_ON: begin
            if (phy_pdown_ctl)
               phy_state_next = rpd_pkg::RPD_PHY_GEN_DOWN;
            else if (phy_edpd_ctl && !line_energy_present)
               phy_state_next = rpd_pkg::RPD_PHY_ED_DOWN;
         end
         rpd_pkg::RPD_PHY_GEN_DOWN: begin
            if (!phy_pdown_ctl)
               phy_state_next = rpd_pkg::RPD_PHY_ON;
         end
         rpd_pkg::RPD_PHY_ED_DOWN: begin
            if (phy_pdown_ctl)
               phy_state_next = rpd_pkg::RPD_PHY_GEN_DOWN;
            else if (line_energy_present || !phy_edpd_ctl)
               phy_state_next = rpd_pkg::RPD_PHY_ON;
         end
         default: phy_state_next = rpd_pkg::RPD_PHY_ON;
      endcase
   end

   // Leaving general power-down forces an automatic PHY reset
   wire gen_wake = (phy_state_reg == rpd_pkg::RPD_PHY_GEN_DOWN) &&
                   (phy_state_next == rpd_pkg::RPD_PHY_ON);
   // Energy wake keeps PHY state, so no reset is issued
   wire ed_wake = (phy_state_reg == rpd_pkg::RPD_PHY_ED_DOWN) &&
                  (phy_state_next == rpd_pkg::RPD_PHY_ON) &&
                  line_energy_present;
   wire bcr_start = phy_bcr_reset_wr & ~hw_active;
   wire auto_start = gen_wake | bcr_start;

   rpd_timer #(.LOAD(24'(`RPD_PHYAUTO_CYC))) u_phyauto (
      .clock(clock),
      .rst_b(rst_b),
      .start(auto_start),
      .busy(phy_auto_busy),
      .done(bcr_done)
   );

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phy_state_reg <= rpd_pkg::RPD_PHY_ON;
         energy_prev_reg <= 1'b0;
      end else if (hw_active) begin
         phy_state_reg <= rpd_pkg::RPD_PHY_ON;
         energy_prev_reg <= line_energy_present;
      end else begin
         phy_state_reg <= phy_state_next;
         energy_prev_reg <= line_energy_present;
      end
   end

   // Set wins over clear so a wake in the clearing cycle is kept
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         energy_flag_reg <= 1'b0;
      else if (hw_active || phy_rst_n == 1'b0)
         energy_flag_reg <= 1'b0;
      else if (ed_wake || (energy_rise &&
               phy_state_reg == rpd_pkg::RPD_PHY_ED_DOWN))
         energy_flag_reg <= 1'b1;
      else if (energy_irq_clr)
         energy_flag_reg <= 1'b0;
   end

   // Bit held set from the write until the PHY reset finishes
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         bcr_busy_reg <= 1'b0;
      else if (bcr_start)
         bcr_busy_reg <= 1'b1;
      else if (bcr_done || hw_active)
         bcr_busy_reg <= 1'b0;
   end

   //--------------------------------------------------------------
   // EEPROM probe and ready sequencing
   //--------------------------------------------------------------
   // Soft reset end or pin release starts a probe; only pin release starts the ready wait
   logic soft_busy_prev_reg;
   wire soft_end = soft_busy_prev_reg & ~soft_busy;
   wire internal_done = hw_release | soft_end;

   rpd_timer #(.LOAD(`RPD_PROBE_CYC)) u_probe (
      .clock(clock),
      .rst_b(rst_b),
      .start(internal_done),
      .busy(probe_busy),
      .done()
   );

   rpd_timer #(.LOAD(24'(`RPD_READY_CYC))) u_ready (
      .clock(clock),
      .rst_b(rst_b),
      .start(hw_release),
      .busy(ready_busy),
      .done(ready_done)
   );

   rpd_pkg::rpd_ready_state_t rdy_state_reg;
   rpd_pkg::rpd_ready_state_t rdy_state_next;

   wire wake_start = wake_test_wr &&
                     rdy_state_reg == rpd_pkg::RPD_RDY_SLEEP;

   // Wake delay kept well inside the 2 ms bound
   rpd_timer #(.LOAD(24'(`RPD_WAKE_CYC / 2))) u_wake (
      .clock(clock),
      .rst_b(rst_b),
      .start(wake_start),
      .busy(),
      .done(wake_done)
   );

   wire any_reset = hw_active | ready_busy | soft_busy;

   always_comb begin
      rdy_state_next = rdy_state_reg;
      case (rdy_state_reg)
         rpd_pkg::RPD_RDY_WAIT: begin
            if (ready_done && !any_reset)
               rdy_state_next = rpd_pkg::RPD_RDY_SET;
         end
         rpd_pkg::RPD_RDY_SET: begin
            if (sleep_enter)
               rdy_state_next = rpd_pkg::RPD_RDY_SLEEP;
         end
         rpd_pkg::RPD_RDY_SLEEP: begin
            if (wake_done)
               rdy_state_next = rpd_pkg::RPD_RDY_SET;
         end
         default: rdy_state_next = rpd_pkg::RPD_RDY_WAIT;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdy_state_reg <= rpd_pkg::RPD_RDY_WAIT;
         soft_busy_prev_reg <= 1'b0;
      end else begin
         soft_busy_prev_reg <= soft_busy;
         if (hw_active)
            rdy_state_reg <= rpd_pkg::RPD_RDY_WAIT;
         else
            rdy_state_reg <= rdy_state_next;
      end
   end

   //--------------------------------------------------------------
   // Strap latch
   //--------------------------------------------------------------
   logic [3:0] strap_reg;

   // Straps caught on the clocked release, never under async reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         strap_reg <= 4'h0;
      else if (hw_release)
         strap_reg <= config_straps;
   end

   //--------------------------------------------------------------
   // Transmit hold after PHY reset
   //--------------------------------------------------------------
   logic tx_hold_reg;
   wire phy_any_reset = hw_active | phy_rst_busy | phy_auto_busy;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         tx_hold_reg <= 1'b1;
      else if (phy_any_reset)
         tx_hold_reg <= 1'b1;
      else if (phy_link_up)
         tx_hold_reg <= 1'b0;
   end

   //--------------------------------------------------------------
   // Outputs
   //--------------------------------------------------------------
   wire phy_down = phy_state_reg != rpd_pkg::RPD_PHY_ON;

   // Ready bit is a gated level so it drops at once with the synchronised pin
   assign ready_flag = (rdy_state_reg == rpd_pkg::RPD_RDY_SET) &
                       ~any_reset;
   assign soft_reset_bit = soft_busy;
   assign phy_reset_bit = phy_rst_busy;
   assign phy_bcr_reset_bit = bcr_busy_reg & phy_auto_busy;
   assign eeprom_busy = probe_busy;
   assign energy_irq_flag = energy_flag_reg;
   assign host_irq = energy_flag_reg & energy_irq_en;
   assign strap_latched = strap_reg;

   assign pll_rst_n = ~hw_active;
   assign not_cleared_by_soft_reset_rst_n = ~hw_active;
   assign host_bus_interface_rst_n = ~(hw_active | soft_busy);
   assign mac_interface_layer_rst_n = ~(hw_active | soft_busy);
   assign mac_rst_n = ~(hw_active | soft_busy);
   // Soft reset leaves the PHY alone
   assign phy_rst_n = ~phy_any_reset;
   assign eeprom_reload = internal_done;

   assign phy_power_on = ~phy_down;
   assign phy_mgmt_on = 1'b1;
   assign phy_squelch_on = phy_state_reg != rpd_pkg::RPD_PHY_GEN_DOWN;
   // Nothing leaves the PHY while down; early wake packets may drop
   assign phy_tx_enable = ~phy_down & ~phy_any_reset;
   assign tx_allow = tx_data_pending & ~tx_hold_reg & ~phy_down;

endmodule : rpd_reset_ctrl

// *** core/rpd_defs.svh ***
/*
 * Timing counts and bit positions for the reset and PHY power-down
 * controller. Assumes a 20 MHz core clock (50 ns period).
 */
`ifndef RPD_DEFS_SVH
`define RPD_DEFS_SVH

`define RPD_CLK_NS 50
// Ready delay after the reset pin is released, in microseconds
`define RPD_READY_US 22000
`define RPD_READY_CYC ((`RPD_READY_US * 1000) / `RPD_CLK_NS)
// Wake to ready, upper bound, in microseconds
`define RPD_WAKE_US 2000
`define RPD_WAKE_CYC ((`RPD_WAKE_US * 1000) / `RPD_CLK_NS)
// Soft reset duration, in nanoseconds
`define RPD_SOFT_NS 2000
`define RPD_SOFT_CYC ((`RPD_SOFT_NS + `RPD_CLK_NS - 1) / `RPD_CLK_NS)
// PHY-only reset duration, in microseconds
`define RPD_PHYRST_US 100
`define RPD_PHYRST_CYC ((`RPD_PHYRST_US * 1000) / `RPD_CLK_NS)
// Automatic PHY reset on power-up or basic-control reset
`define RPD_PHYAUTO_CYC `RPD_PHYRST_CYC
// EEPROM probe time after a full or soft reset
`define RPD_PROBE_CYC 24'h000100

`define RPD_SOFT_RESET_BIT 0
`define RPD_PHY_RESET_BIT 10
`define RPD_PHY_PDOWN_BIT 11
`define RPD_PHY_BCR_RESET_BIT 15
`define RPD_PHY_EDPD_BIT 13
`define RPD_PHY_LINK_BIT 2
`define RPD_EEPROM_BUSY_BIT 31

`endif

// *** core/rpd_pkg.sv ***
/*
 * Types shared by the reset and PHY power-down controller.
 * Assumes rpd_defs.svh holds the numeric constants.
 */
package rpd_pkg;

   typedef enum logic [1:0] {
      RPD_PHY_ON,
      RPD_PHY_GEN_DOWN,
      RPD_PHY_ED_DOWN
   } rpd_phy_state_t;

   typedef enum logic [1:0] {
      RPD_RDY_WAIT,
      RPD_RDY_SET,
      RPD_RDY_SLEEP
   } rpd_ready_state_t;

endpackage : rpd_pkg

// *** core/rpd_timer.sv ***
/*
 * One-shot down counter: a start pulse loads the count, busy stays
 * high until it runs out. Assumes start comes from the same clock.
 */
`timescale 1ns/10ps

module rpd_timer #(
   parameter logic [23:0] LOAD = 24'h000001
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Control
   input wire logic start,
   output logic busy,
   output logic done
);

   logic [23:0] count_reg;
   logic [23:0] count_next;
   logic busy_reg;
   logic busy_next;
   logic done_reg;

   // A new start restarts the count; this stretches overlapping requests
   assign count_next = start ? LOAD :
                       (count_reg != 24'h000000) ? count_reg - 24'h000001 :
                       count_reg;
   assign busy_next = start | (busy_reg & (count_reg > 24'h000001));

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= 24'h000000;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         busy_reg <= busy_next;
         done_reg <= busy_reg & ~busy_next;
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;

endmodule : rpd_timer

// *** tb/rpd_reset_ctrl_asserts.sv ***
/* Port checker for rpd_reset_ctrl.
   Assumes it is bound to the top module on its 20 MHz clock. */
`timescale 1ns/10ps
module rpd_reset_ctrl_asserts (
   // Clock, reset, pin
   input wire logic clock,
   input wire logic rst_b,
   input wire logic hw_reset_n_pin,
   // Watched controls
   input wire logic soft_reset_wr,
   input wire logic phy_reset_wr,
   input wire logic phy_bcr_reset_wr,
   input wire logic phy_pdown_ctl,
   input wire logic phy_edpd_ctl,
   input wire logic energy_irq_en,
   input wire logic line_energy_present,
   input wire logic phy_link_up,
   // Watched results
   input wire logic ready_flag,
   input wire logic soft_reset_bit,
   input wire logic phy_reset_bit,
   input wire logic phy_bcr_reset_bit,
   input wire logic eeprom_busy,
   input wire logic energy_irq_flag,
   input wire logic host_irq,
   input wire logic pll_rst_n,
   input wire logic not_cleared_by_soft_reset_rst_n,
   input wire logic mac_rst_n,
   input wire logic host_bus_interface_rst_n,
   input wire logic phy_rst_n,
   input wire logic eeprom_reload,
   input wire logic phy_power_on,
   input wire logic phy_mgmt_on,
   input wire logic phy_squelch_on,
   input wire logic phy_tx_enable,
   input wire logic tx_allow
);
   // ----------------------------------------
   // Helper counter and sequences
   // ----------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   int unsigned phy_cnt;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) phy_cnt <= 0;
      else phy_cnt <= phy_reset_bit ? phy_cnt + 1 : 0;
   end
   sequence s_probe;
      ##[0:1] eeprom_reload ##[0:1] eeprom_busy;
   endsequence
   sequence s_soft_run;
      ##39 soft_reset_bit ##1 !soft_reset_bit;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_soft_go;
      soft_reset_wr && pll_rst_n |=> soft_reset_bit && !mac_rst_n
         && !host_bus_interface_rst_n;
   endproperty
   property p_soft_len;
      $rose(soft_reset_bit) |-> s_soft_run;
   endproperty
   property p_soft_scope;
      soft_reset_bit |-> pll_rst_n && not_cleared_by_soft_reset_rst_n && phy_rst_n;
   endproperty
   property p_probe;
      $fell(soft_reset_bit) |-> s_probe;
   endproperty
   property p_phy_go;
      phy_reset_wr && pll_rst_n |=> phy_reset_bit && !phy_rst_n;
   endproperty
   property p_phy_len;
      $fell(phy_reset_bit) |-> phy_cnt == 2000;
   endproperty
   property p_bcr_go;
      phy_bcr_reset_wr && pll_rst_n |=> phy_bcr_reset_bit && !phy_rst_n;
   endproperty
   property p_pdown;
      phy_pdown_ctl [*3] |-> !phy_power_on && phy_mgmt_on;
   endproperty
   property p_pdown_exit;
      $fell(phy_pdown_ctl) |-> ##[0:3] !phy_rst_n;
   endproperty
   property p_edpd;
      (phy_edpd_ctl && !line_energy_present && !phy_pdown_ctl) [*3] |->
         !phy_power_on && !phy_tx_enable && phy_squelch_on;
   endproperty
   property p_energy;
      $rose(line_energy_present) && phy_edpd_ctl && pll_rst_n
         |-> ##[1:3] energy_irq_flag;
   endproperty
   property p_irq;
      host_irq == (energy_irq_flag && energy_irq_en);
   endproperty
   property p_pin_low;
      !hw_reset_n_pin [*3] |-> !ready_flag && !pll_rst_n && !not_cleared_by_soft_reset_rst_n
         && !mac_rst_n && !phy_rst_n;
   endproperty
   property p_ready_clear;
      ready_flag |-> pll_rst_n && mac_rst_n && host_bus_interface_rst_n;
   endproperty
   property p_tx_hold;
      !phy_rst_n ##1 !phy_link_up |-> !tx_allow;
   endproperty
   a_soft_go: assert property (p_soft_go) else $error("soft go");
   a_soft_len: assert property (p_soft_len) else $error("soft len");
   a_soft_scope: assert property (p_soft_scope) else $error("scope");
   a_probe: assert property (p_probe) else $error("probe");
   a_phy_go: assert property (p_phy_go) else $error("phy go");
   a_phy_len: assert property (p_phy_len) else $error("phy len");
   a_bcr_go: assert property (p_bcr_go) else $error("bcr go");
   a_pdown: assert property (p_pdown) else $error("pdown");
   a_pdown_exit: assert property (p_pdown_exit) else $error("pup");
   a_edpd: assert property (p_edpd) else $error("edpd");
   a_energy: assert property (p_energy) else $error("energy");
   a_irq: assert property (p_irq) else $error("irq");
   a_pin_low: assert property (p_pin_low) else $error("pin low");
   a_ready_clear: assert property (p_ready_clear) else $error("rdy");
   a_tx_hold: assert property (p_tx_hold) else $error("tx hold");
endmodule : rpd_reset_ctrl_asserts

// *** tb/rpd_host_model.sv ***
/* Host side model: turns one command strobe into register write pulses.
   Assumes go is raised for one cycle just after a falling edge. */
`timescale 1ns/10ps
module rpd_host_model (
   // Command from bench
   input wire logic go,
   input wire logic [2:0] cmd,
   input wire logic ready_flag,
   // Write pulses
   output logic soft_reset_wr,
   output logic phy_reset_wr,
   output logic phy_bcr_reset_wr,
   output logic wake_test_wr,
   output logic sleep_enter
);
   // Soft reset write passed only while ready, as a careful host does
   assign soft_reset_wr = go && cmd == 3'h0 && ready_flag;
   assign phy_reset_wr = go && cmd == 3'h1;
   assign phy_bcr_reset_wr = go && cmd == 3'h2;
   assign wake_test_wr = go && cmd == 3'h3;
   assign sleep_enter = go && cmd == 3'h4;
endmodule : rpd_host_model

// *** tb/tb_top.sv ***
/* Self-checking bench for rpd_reset_ctrl.
   Assumes the full-length ready wait (no parameter shortens it). */
`timescale 1ns/10ps
module tb_top;
   logic clock, rst_b, hw_reset_n_pin, go, soft_reset_wr, phy_reset_wr;
   logic phy_bcr_reset_wr, wake_test_wr, sleep_enter, phy_pdown_ctl;
   logic phy_edpd_ctl, energy_irq_en, energy_irq_clr, line_energy_present;
   logic phy_link_up, tx_data_pending, ready_flag, soft_reset_bit;
   logic phy_reset_bit, phy_bcr_reset_bit, eeprom_busy, energy_irq_flag;
   logic host_irq, pll_rst_n, host_bus_interface_rst_n, not_cleared_by_soft_reset_rst_n;
   logic mac_interface_layer_rst_n, mac_rst_n, phy_rst_n, eeprom_reload;
   logic phy_power_on, phy_mgmt_on, phy_squelch_on, phy_tx_enable, tx_allow;
   logic [3:0] config_straps, strap_latched;
   logic [2:0] cmd;
   logic [31:0] rnd;
   int fails, check_count, cyc, n;
   rpd_reset_ctrl DUT (.*);
   rpd_host_model u_host (.*);
   // ----------------------------------------
   // Clock, timeout, helpers
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 480000) begin
         fails++;
         report_and_stop;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(negedge clock);
   endtask : tick
   task automatic host(input int c);
      cmd = c[2:0];
      go = 1'b1;
      tick(1);
      go = 1'b0;
   endtask : host
   function automatic logic pick(input int s);
      case (s)
         0: return soft_reset_bit;
         1: return phy_reset_bit;
         2: return phy_bcr_reset_bit;
         3: return eeprom_busy;
         4: return !ready_flag;
         default: return !phy_rst_n;
      endcase
   endfunction : pick
   // Cycles for which the picked level stays high, bounded
   task automatic span(input int s, input int lim, output int k);
      k = 0;
      while (pick(s) === 1'b1 && k < lim) begin
         tick(1);
         k++;
      end
   endtask : span
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_b, hw_reset_n_pin, go, cmd, phy_pdown_ctl, phy_edpd_ctl} = '0;
      {energy_irq_en, energy_irq_clr, line_energy_present} = '0;
      {phy_link_up, tx_data_pending} = '0;
      rnd = 32'he17a7592;
      config_straps = rnd[3:0];
      tick(2);
      rst_b = 1'b1;
      tick(10); // pin held low after power-up
      chk({ready_flag, pll_rst_n, not_cleared_by_soft_reset_rst_n, mac_rst_n}, 4'h0);
      chk({phy_rst_n, host_bus_interface_rst_n}, 2'h0);
      rnd = lfsr(rnd);
      config_straps = rnd[7:4];
      hw_reset_n_pin = 1'b1;
      tick(6);
      chk(strap_latched, rnd[7:4]);
      span(4, 440100, n);
      // Span starts six cycles after the pin release
      chk(n + 6 >= 440000 && n + 6 <= 440010, 1'b1);
      host(0);
      chk({mac_rst_n, pll_rst_n, not_cleared_by_soft_reset_rst_n, phy_rst_n}, 4'h7);
      chk({host_bus_interface_rst_n, mac_interface_layer_rst_n}, 2'h0);
      span(0, 100, n);
      chk(n, 40);
      for (int i = 0; i < 4 && !eeprom_busy; i++) tick(1);
      span(3, 300, n);
      chk(n, 256);
      for (int c = 1; c < 3; c++) begin
         host(c);
         chk({phy_rst_n, mac_rst_n}, 2'h1);
         span(c, 2100, n);
         chk(n, 2000);
      end
      phy_pdown_ctl = 1'b1;
      tick(4);
      chk({phy_power_on, phy_mgmt_on}, 2'h1);
      phy_pdown_ctl = 1'b0;
      tick(2);
      chk(phy_rst_n, 1'b0);
      tx_data_pending = 1'b1;
      tick(1);
      chk(tx_allow, 1'b0);
      span(5, 2100, n);
      chk(n + 2, 2000);
      chk(phy_power_on, 1'b1);
      phy_link_up = 1'b1;
      tick(2);
      chk(tx_allow, 1'b1);
      phy_edpd_ctl = 1'b1;
      tick(4);
      chk({phy_power_on, phy_tx_enable, phy_squelch_on}, 3'h1);
      line_energy_present = 1'b1;
      tick(3);
      chk({energy_irq_flag, phy_power_on, host_irq}, 3'h6);
      energy_irq_en = 1'b1;
      tick(1);
      chk(host_irq, 1'b1);
      line_energy_present = 1'b0;
      energy_irq_clr = 1'b1;
      tick(1);
      energy_irq_clr = 1'b0;
      tick(1);
      chk({energy_irq_flag, host_irq}, 2'h0);
      phy_edpd_ctl = 1'b0;
      rnd = lfsr(rnd);
      tx_data_pending = rnd[0];
      host(4);
      tick(2);
      chk(ready_flag, 1'b0);
      host(3);
      span(4, 41000, n);
      chk(n > 0 && n <= 40000, 1'b1);
      chk(tx_allow, rnd[0]);
      report_and_stop;
   end
endmodule : tb_top
bind rpd_reset_ctrl rpd_reset_ctrl_asserts u_chk (.*);
